// ### rtl/sbt_pkg.sv
// package of constants and types for the three-port serial block with baud timers
// What this block does
// R1: writing the buffer starts transmission; reading it returns a separate receive register
// R2: receiver is double buffered; a newly completed byte replaces the unread one; here it is dropped while the receive flag is set
// R3: mode bits pick shift, 8-bit timer rate, 9-bit fixed rate, 9-bit timer rate
// R4: multiprocessor bit suppresses receive flag on ninth zero or bad stop; none in shift mode
// R5: hardware sets transmit and receive done flags; only software clears them
// R6: shift mode receives when enabled with flag clear; others start on start bit
// R7: shift mode moves eight bits LSB first on receive pin, clock on transmit pin
// R8: shift transmit starts four machine cycles after write, ends in 36th; receive takes 36
// R9: 8-bit frame is start, eight data LSB first, stop; stop bit stored as ninth
// R10: receiver finds falling edge, samples sixteen per bit, votes on samples 7, 8, 9
// R11: 8-bit frame kept only if flag clear and filter clear or stop is one
// R12: 9-bit frame is start, eight data, transmit ninth bit, stop; stop ignored on receive
// R13: 9-bit transmission ends and sets done flag at eleventh bit time after write
// R14: 9-bit frame kept only if flag clear and filter clear or ninth bit is one
// R15: fixed 9-bit rate is clock over 64, 32 or 16 by extra and double bits
// R16: timer-rate modes follow selected baud timer overflow scaled by double and extra bits
// R17: each dedicated timer is 8-bit auto-reload, counts machine cycles of three clocks
// R18: run bits 0, 1 and 3 start the timers of ports 0, 1 and 2
// R19: windowed count and reload addresses pick timer 1 or one dedicated timer; here timer 1 is outside and window 000 reads zero
// R20: clock-select bit makes a timer count clocks; upper four bits read zero
// R21: software must not reload 0xFF or 0xFE into a timer counting clocks
// R22: running dedicated timer beats timer 2, which beats timer 1
// R23: control and status registers read zero after reset
package sbt_pkg;

  localparam int NPORT = 3;

  // register map, byte addresses on the plain register port
  localparam logic [3:0] A_CTRL0 = 4'h0;
  localparam logic [3:0] A_BUF0 = 4'h1;
  localparam logic [3:0] A_CTRL1 = 4'h2;
  localparam logic [3:0] A_BUF1 = 4'h3;
  localparam logic [3:0] A_CTRL2 = 4'h4;
  localparam logic [3:0] A_BUF2 = 4'h5;
  localparam logic [3:0] A_TCNT = 4'h6;
  localparam logic [3:0] A_TRLD = 4'h7;
  localparam logic [3:0] A_RUN = 4'h8;
  localparam logic [3:0] A_CLKSEL = 4'h9;
  localparam logic [3:0] A_OPT = 4'hA;

  // run and window register layout
  localparam int RUN_BIT [NPORT] = '{0, 1, 3};
  localparam logic [7:0] RUN_MASK = 8'hEB;
  localparam int WIN_LSB = 5;
  localparam logic [2:0] WIN_SEL [NPORT] = '{3'h1, 3'h2, 3'h4};
  localparam logic [7:0] CLKSEL_MASK = 8'h0F;

  // option register layout
  localparam int OPT_DOUBLE = 0;
  localparam int OPT_EXTRA = 1;
  localparam int OPT_T2SEL = 2;
  localparam logic [7:0] OPT_MASK = 8'h07;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;

  // modes
  localparam logic [1:0] MODE_SHIFT = 2'b00;
  localparam logic [1:0] MODE_UART8 = 2'b01;
  localparam logic [1:0] MODE_FIX9 = 2'b10;
  localparam logic [1:0] MODE_VAR9 = 2'b11;

  // timing counts
  localparam logic [1:0] MC_CLKS = 2'd3;
  localparam logic [5:0] M0_START_MC = 6'd4;
  localparam logic [5:0] M0_END_MC = 6'd36;
  localparam logic [3:0] OVS_LAST = 4'd15;
  localparam logic [3:0] SMP_A = 4'd6;
  localparam logic [3:0] SMP_B = 4'd7;
  localparam logic [3:0] SMP_C = 4'd8;
  localparam logic [3:0] RX_LAST_BIT = 4'd9;
  localparam logic [3:0] TX_BITS8 = 4'd10;
  localparam logic [3:0] TX_BITS9 = 4'd11;
  localparam logic [1:0] FIX_DIV64 = 2'd3;
  localparam logic [1:0] FIX_DIV32 = 2'd1;
  localparam logic [1:0] FIX_DIV16 = 2'd0;

  // control and status register of one port
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_filter_bit;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } sbt_ctrl_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_M0 = 3'b010,
    TX_ASYNC = 3'b100
  } sbt_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_M0 = 3'b010,
    RX_ASYNC = 3'b100
  } sbt_rx_st_t;

endpackage

// ### rtl/sbt_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sbt_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // idle serial lines are high, so both stages reset high
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/sbt_baud_timer.sv
// 8-bit auto-reload baud timer of one serial port
`timescale 1ns/1ps
`default_nettype none
module sbt_baud_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic count_en_i,
  // software access
  input wire logic cnt_we_i,
  input wire logic rld_we_i,
  input wire logic [7:0] wdata_i,
  // state
  output logic [7:0] count_o,
  output logic [7:0] reload_o,
  output logic ovf_o
);
  logic adv;

  // no prescaler: one step per enable while running
  assign adv = run_i & count_en_i; // see R17

  // counter with reload on rollover; software write wins over counting
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_o <= 8'h00;
    end else if (cnt_we_i) begin
      count_o <= wdata_i;
    end else if (adv) begin
      count_o <= (count_o == 8'hFF) ? reload_o : count_o + 8'h01; // see R17
    end
  end

  // reload byte
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reload_o <= 8'h00;
    end else if (rld_we_i) begin
      reload_o <= wdata_i;
    end
  end

  // overflow pulse, one clock late; no interrupt path exists
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= adv & ~cnt_we_i & (count_o == 8'hFF);
    end
  end
endmodule
`default_nettype wire

// ### rtl/sbt_serial_top.sv
// three serial ports with shift and asynchronous modes and dedicated baud timers
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sbt_serial_top
  import sbt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // overflow pulses of timer 1 and timer 2, same clock
  input wire logic t1_ovf_i,
  input wire logic t2_ovf_i,
  // serial pins
  input wire logic [NPORT-1:0] rxd_i,
  output logic [NPORT-1:0] rxd_o,
  output logic [NPORT-1:0] rxd_oe_o,
  output logic [NPORT-1:0] txd_o
);
  logic [1:0] mc_cnt_q;
  logic mc_tick;
  logic [7:0] run_q;
  logic [3:0] clksel_q;
  logic [7:0] opt_q;
  logic [NPORT-1:0] rxd_s;
  logic [2:0] win;
  logic [7:0] rd_mux;
  sbt_ctrl_t ctrl_q [NPORT];
  logic [7:0] rxbuf_q [NPORT];
  logic [7:0] tcnt [NPORT];
  logic [7:0] trld [NPORT];
  logic [NPORT-1:0] ded_ovf;

  // machine cycle enable: one pulse every three clocks
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mc_cnt_q <= 2'd0;
    end else begin
      mc_cnt_q <= mc_tick ? 2'd0 : mc_cnt_q + 2'd1;
    end
  end
  assign mc_tick = (mc_cnt_q == MC_CLKS - 2'd1); // see R17

  sbt_sync #(.WIDTH(NPORT)) u_rx_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(rxd_i),
    .sync_o(rxd_s)
  );

  // run/window, clock-select and option registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q <= REG_RST;
      clksel_q <= 4'h0;
      opt_q <= REG_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == A_RUN) begin
        run_q <= reg_wdata_i & RUN_MASK; // see R18
      end
      if (reg_addr_i == A_CLKSEL) begin
        clksel_q <= reg_wdata_i[3:0]; // see R20
      end
      if (reg_addr_i == A_OPT) begin
        opt_q <= reg_wdata_i & OPT_MASK;
      end
    end
  end
  assign win = run_q[WIN_LSB+2:WIN_LSB];

  // read mux; window 000 is timer 1, which lives outside and reads zero
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      A_CTRL0: rd_mux = ctrl_q[0];
      A_BUF0: rd_mux = rxbuf_q[0]; // see R1
      A_CTRL1: rd_mux = ctrl_q[1];
      A_BUF1: rd_mux = rxbuf_q[1];
      A_CTRL2: rd_mux = ctrl_q[2];
      A_BUF2: rd_mux = rxbuf_q[2];
      A_TCNT: begin
        for (int k = 0; k < NPORT; k++) begin
          if (win == WIN_SEL[k]) begin
            rd_mux = tcnt[k]; // see R19
          end
        end
      end
      A_TRLD: begin
        for (int k = 0; k < NPORT; k++) begin
          if (win == WIN_SEL[k]) begin
            rd_mux = trld[k];
          end
        end
      end
      A_RUN: rd_mux = run_q;
      A_CLKSEL: rd_mux = {4'h0, clksel_q} & CLKSEL_MASK; // see R20
      A_OPT: rd_mux = opt_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic ctrl_wr;
    logic buf_wr;
    logic [1:0] mode;
    logic var_src;
    logic var_half_q;
    logic var_tick;
    logic [1:0] fix_cnt_q;
    logic [1:0] fix_div;
    logic fix_tick;
    logic tick16;
    sbt_tx_st_t tx_st_q;
    sbt_rx_st_t rx_st_q;
    logic [5:0] m0_cnt_q;
    logic m0_act;
    logic m0_shift_ph;
    logic m0_last;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_tick_q;
    logic [3:0] tx_bit_q;
    logic [3:0] tx_nbits;
    logic tx_async_done;
    logic ti_set;
    logic [7:0] rx_sh_q;
    logic [3:0] rx_smp_q;
    logic [3:0] rx_bit_q;
    logic [1:0] vote_q;
    logic maj;
    logic rxd_p_q;
    logic rx_go_m0;
    logic rx_m0_done;
    logic rx_async_last;
    logic rx_accept;
    logic ri_set;
    logic txd_d;

    sbt_baud_timer u_tmr (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(run_q[RUN_BIT[p]]), // see R18
      .count_en_i(clksel_q[p] | mc_tick), // see R20 (R21 left to software)
      .cnt_we_i(reg_wr_i && reg_addr_i == A_TCNT && win == WIN_SEL[p]), // see R19
      .rld_we_i(reg_wr_i && reg_addr_i == A_TRLD && win == WIN_SEL[p]),
      .wdata_i(reg_wdata_i),
      .count_o(tcnt[p]),
      .reload_o(trld[p]),
      .ovf_o(ded_ovf[p])
    );

    assign ctrl_wr = reg_wr_i && reg_addr_i == A_CTRL0 + 4'(2 * p);
    assign buf_wr = reg_wr_i && reg_addr_i == A_BUF0 + 4'(2 * p);
    assign mode = {ctrl_q[p].mode_select_high, ctrl_q[p].mode_select_low}; // see R3

    // baud source: dedicated timer while running, else timer 2 or timer 1 by the select bit
    assign var_src = run_q[RUN_BIT[p]] ? ded_ovf[p] :
                     (opt_q[OPT_T2SEL] ? t2_ovf_i : t1_ovf_i); // see R22

    // without double or extra the sample rate is half the overflow rate
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        var_half_q <= 1'b0;
      end else if (var_src) begin
        var_half_q <= ~var_half_q;
      end
    end
    assign var_tick = var_src & (opt_q[OPT_DOUBLE] | opt_q[OPT_EXTRA] | var_half_q); // see R16

    // fixed rate: sixteen samples per bit at clock/64, /32 or /16
    always_comb begin
      case ({opt_q[OPT_EXTRA], opt_q[OPT_DOUBLE]})
        2'b00: fix_div = FIX_DIV64; // see R15
        2'b11: fix_div = FIX_DIV16;
        default: fix_div = FIX_DIV32;
      endcase
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        fix_cnt_q <= 2'd0;
      end else begin
        fix_cnt_q <= fix_tick ? 2'd0 : fix_cnt_q + 2'd1;
      end
    end
    assign fix_tick = (fix_cnt_q >= fix_div);
    assign tick16 = (mode == MODE_FIX9) ? fix_tick : var_tick; // see R3

    // shift mode shares one machine cycle counter between directions
    assign m0_act = (tx_st_q == TX_M0) || (rx_st_q == RX_M0);
    assign m0_shift_ph = m0_act && mc_tick && m0_cnt_q >= M0_START_MC;
    assign m0_last = m0_act && mc_tick && m0_cnt_q == M0_END_MC - 6'd1; // see R8
    assign rx_go_m0 = rx_st_q == RX_IDLE && tx_st_q == TX_IDLE && !buf_wr &&
                      mode == MODE_SHIFT && ctrl_q[p].receive_enable &&
                      !ctrl_q[p].receive_done_flag; // see R6
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        m0_cnt_q <= 6'd0;
      end else if (rx_go_m0 || (buf_wr && mode == MODE_SHIFT && rx_st_q != RX_M0)) begin
        m0_cnt_q <= 6'd0;
      end else if (m0_act && mc_tick) begin
        m0_cnt_q <= m0_cnt_q + 6'd1;
      end
    end

    // transmitter; a write while busy restarts the frame
    assign tx_nbits = (mode == MODE_UART8) ? TX_BITS8 : TX_BITS9;
    assign tx_async_done = tx_st_q == TX_ASYNC && tick16 && tx_tick_q == OVS_LAST &&
                           tx_bit_q == tx_nbits - 4'd1; // see R13
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        tx_st_q <= TX_IDLE;
        tx_sh_q <= '1;
        tx_tick_q <= 4'd0;
        tx_bit_q <= 4'd0;
      end else if (buf_wr && mode == MODE_SHIFT) begin
        if (rx_st_q != RX_M0) begin
          tx_st_q <= TX_M0; // see R1
          tx_sh_q <= {3'b111, reg_wdata_i};
        end
      end else if (buf_wr) begin
        tx_st_q <= TX_ASYNC; // see R1
        tx_sh_q <= {1'b1, (mode == MODE_UART8) | ctrl_q[p].transmit_ninth_bit,
                    reg_wdata_i, 1'b0}; // see R9 R12
        tx_tick_q <= 4'd0;
        tx_bit_q <= 4'd0;
      end else begin
        case (tx_st_q)
          TX_M0: begin
            if (m0_last) begin
              tx_st_q <= TX_IDLE;
            end else if (m0_shift_ph && m0_cnt_q[1:0] == 2'd3) begin
              tx_sh_q <= {1'b1, tx_sh_q[10:1]}; // see R7
            end
          end
          TX_ASYNC: begin
            if (tick16) begin
              tx_tick_q <= tx_tick_q + 4'd1;
              if (tx_tick_q == OVS_LAST) begin
                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                tx_bit_q <= tx_bit_q + 4'd1;
                if (tx_async_done) begin
                  tx_st_q <= TX_IDLE;
                end
              end
            end
          end
          TX_IDLE: tx_st_q <= TX_IDLE;
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
    assign ti_set = (tx_st_q == TX_M0 && m0_last) || tx_async_done; // see R5 R8

    // pins: shift clock low in the first half of each four-cycle bit
    always_comb begin
      if (m0_act) begin
        txd_d = !(m0_cnt_q >= M0_START_MC && !m0_cnt_q[1]); // see R7
      end else if (tx_st_q == TX_ASYNC) begin
        txd_d = tx_sh_q[0];
      end else begin
        txd_d = 1'b1;
      end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        txd_o[p] <= 1'b1;
        rxd_o[p] <= 1'b1;
        rxd_oe_o[p] <= 1'b0;
      end else begin
        txd_o[p] <= txd_d;
        rxd_o[p] <= tx_sh_q[0];
        rxd_oe_o[p] <= tx_st_q == TX_M0 && m0_cnt_q >= M0_START_MC; // see R7
      end
    end

    // receiver: previous line level for falling-edge detection
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        rxd_p_q <= 1'b1;
      end else begin
        rxd_p_q <= rxd_s[p];
      end
    end
    assign maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & rxd_s[p]) |
                 (vote_q[1] & rxd_s[p]); // see R10
    assign rx_async_last = rx_st_q == RX_ASYNC && tick16 && rx_smp_q == SMP_C &&
                           rx_bit_q == RX_LAST_BIT;
    // one test serves stop and ninth bit, both at bit index nine
    assign rx_accept = !ctrl_q[p].receive_done_flag &&
                       (!ctrl_q[p].multiprocessor_filter_bit || maj); // see R4 R11 R14
    assign rx_m0_done = rx_st_q == RX_M0 && m0_last; // see R8
    assign ri_set = rx_m0_done || (rx_async_last && rx_accept);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        rx_st_q <= RX_IDLE;
        rx_sh_q <= 8'h00;
        rx_smp_q <= 4'd0;
        rx_bit_q <= 4'd0;
        vote_q <= 2'b00;
      end else begin
        case (rx_st_q)
          RX_IDLE: begin
            if (rx_go_m0) begin
              rx_st_q <= RX_M0; // see R6
            end else if (mode != MODE_SHIFT && ctrl_q[p].receive_enable &&
                         rxd_p_q && !rxd_s[p]) begin
              rx_st_q <= RX_ASYNC; // see R6 R10
              rx_smp_q <= 4'd0;
              rx_bit_q <= 4'd0;
            end
          end
          RX_M0: begin
            if (m0_last) begin
              rx_st_q <= RX_IDLE;
            end else if (m0_shift_ph && m0_cnt_q[1:0] == 2'd1) begin
              rx_sh_q <= {rxd_s[p], rx_sh_q[7:1]}; // see R7
            end
          end
          RX_ASYNC: begin
            if (!ctrl_q[p].receive_enable) begin
              rx_st_q <= RX_IDLE;
            end else if (tick16) begin
              rx_smp_q <= rx_smp_q + 4'd1;
              if (rx_smp_q == SMP_A) begin
                vote_q[0] <= rxd_s[p];
              end
              if (rx_smp_q == SMP_B) begin
                vote_q[1] <= rxd_s[p];
              end
              if (rx_smp_q == SMP_C) begin
                if (rx_bit_q == 4'd0 && maj) begin
                  rx_st_q <= RX_IDLE; // false start bit
                end else if (rx_bit_q == RX_LAST_BIT) begin
                  rx_st_q <= RX_IDLE;
                end else if (rx_bit_q != 4'd0) begin
                  rx_sh_q <= {maj, rx_sh_q[7:1]}; // see R9 R12
                end
              end
              if (rx_smp_q == OVS_LAST) begin
                rx_bit_q <= rx_bit_q + 4'd1;
              end
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end

    // holding register: loaded only when a reception sets the receive flag
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        rxbuf_q[p] <= 8'h00;
      end else if (ri_set) begin
        rxbuf_q[p] <= rx_sh_q; // see R2
      end
    end

    // control register; a hardware set wins over a software clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        ctrl_q[p] <= CTRL_RST; // see R23
      end else begin
        if (ctrl_wr) begin
          ctrl_q[p] <= reg_wdata_i;
        end
        if (ctrl_wr && !(rx_async_last && rx_accept)) begin
          ctrl_q[p].received_ninth_bit <= reg_wdata_i[2];
        end else if (rx_async_last && rx_accept) begin
          ctrl_q[p].received_ninth_bit <= maj; // see R9 R12
        end
        if (ti_set) begin
          ctrl_q[p].transmit_done_flag <= 1'b1; // see R5
        end
        if (ri_set) begin
          ctrl_q[p].receive_done_flag <= 1'b1; // see R5
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/sbt_serial_top_asserts.sv
// concurrent checks on register port and pin timing of the serial block
`timescale 1ns/1ps
`default_nettype none
module sbt_serial_top_asserts
  import sbt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // serial pins
  input wire logic [NPORT-1:0] rxd_oe_o,
  input wire logic [NPORT-1:0] txd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // shift-port buffer write while its data pin is released
  sequence s_buf2_wr;
    reg_wr_i && reg_addr_i == A_BUF2 && !rxd_oe_o[2];
  endsequence
  // read data only stand in the answer cycle
  chk_idle_rdata: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("stray read data");
  chk_unmapped_zero: assert property ($past(reg_rd_i && reg_addr_i > A_OPT)
    |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_run_reserved: assert property ($past(reg_rd_i && reg_addr_i == A_RUN)
    |-> (reg_rdata_o & ~RUN_MASK) == 8'h00) else $error("run reserved bits set");
  chk_clksel_upper: assert property ($past(reg_rd_i && reg_addr_i == A_CLKSEL)
    |-> (reg_rdata_o & ~CLKSEL_MASK) == 8'h00) else $error("clksel upper bits set");
  // shift data waits four machine cycles, then takes the pin
  chk_shift_delay: assert property (s_buf2_wr |=> !rxd_oe_o[2] [*8])
    else $error("shift data early");
  chk_shift_start: assert property (s_buf2_wr |-> ##[10:16] rxd_oe_o[2])
    else $error("shift tx missing");
  // shift clock halves are two machine cycles each
  chk_shift_clk_high: assert property ($rose(txd_o[2]) && rxd_oe_o[2] |=> txd_o[2] [*5])
    else $error("shift clock high short");
  chk_shift_clk_low: assert property ($fell(txd_o[2]) && rxd_oe_o[2] |=> !txd_o[2] [*5])
    else $error("shift clock low short");
  // a start bit lasts at least nine clocks
  chk_start_bit_len: assert property ($fell(txd_o[1]) |=> !txd_o[1] [*8])
    else $error("start bit too short");
endmodule
bind sbt_serial_top sbt_serial_top_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
`default_nettype wire

// ### tb/sbt_uart_peer.sv
// remote asynchronous serial device: sends and samples frames
`timescale 1ns/1ps
`default_nettype none
module sbt_uart_peer (
  // clock and lines
  input wire logic clk_i,
  input wire logic tx_line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // start, eight data LSB first, ninth or stop, stop; idles high after
  task automatic send(input logic [8:0] v, input int nb, input int per);
    logic [10:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < nb; i++) begin
      line_o <= f[i];
      repeat (per) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
  // samples at mid-bit, so a wrong bit rate garbles the data
  task automatic recv(input int nb, input int per, output logic [8:0] v);
    logic [10:0] f;
    f = 11'h7FF;
    @(negedge tx_line_i);
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      f[i] = tx_line_i;
      repeat (per) @(posedge clk_i);
    end
    v = f[9:1];
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the three-port serial block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  import sbt_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic t1_ovf_i = 1'b1; // flooding timer 1, never selected: port 0 runs with timer 2 chosen, so its dedicated timer must beat timer 2
  logic t2_ovf_i = 1'b0;
  wire logic [NPORT-1:0] rxd_i;
  logic [7:0] reg_rdata_o;
  logic [NPORT-1:0] rxd_o, rxd_oe_o, txd_o;
  logic p0_line, p1_line;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  logic [31:0] seed = 32'h000173E7;
  logic [7:0] d, r;
  logic [8:0] v;
  logic mp, n;
  // port 2 data pin idles high; only shift mode uses it here
  assign rxd_i = {1'b1, p1_line, p0_line};
  sbt_serial_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .t1_ovf_i(t1_ovf_i), .t2_ovf_i(t2_ovf_i), .rxd_i(rxd_i),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
  sbt_uart_peer p0 (.clk_i(clk_i), .tx_line_i(txd_o[0]), .line_o(p0_line));
  sbt_uart_peer p1 (.clk_i(clk_i), .tx_line_i(txd_o[1]), .line_o(p1_line));
  initial forever #2.5 clk_i = ~clk_i;
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // control after a reception: flag only if filter clear or ninth bit one
  function automatic logic [7:0] rx_ctrl(logic [1:0] m, logic f, logic b);
    return {m, f, 1'b1, 1'b0, b, 1'b0, !f || b};
  endfunction
  function automatic int bit_per(logic [1:0] o);
    return o == 2'b00 ? 64 : (o == 2'b11 ? 16 : 32);
  endfunction
  task automatic rnd();
    repeat (8) seed = lfsr(seed);
    d = seed[7:0];
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= x;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 x = reg_rdata_o;
  endtask
  // bounded wait for a status bit
  task automatic poll(input logic [3:0] a, input int b);
    for (int i = 0; i < 400; i++) begin
      rd(a, r);
      if (r[b] === 1'b1) break;
    end
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // all places read zero after reset
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], r);
      `CHK(r, 8'h00)
    end
    wr(A_CLKSEL, 8'hFF);
    rd(A_CLKSEL, r);
    `CHK(r, CLKSEL_MASK)
    wr(A_RUN, 8'hFF);
    rd(A_RUN, r);
    `CHK(r, RUN_MASK)
    tdone("registers");
    // fixed-rate 9-bit transmit under every rate code
    for (int k = 0; k < 4; k++) begin
      rnd();
      wr(A_OPT, k[7:0]);
      wr(A_CTRL1, {4'h8, seed[8], 3'h0});
      fork
        p1.recv(11, bit_per(k[1:0]), v);
        wr(A_BUF1, d);
      join
      `CHK(v, {seed[8], d})
      poll(A_CTRL1, 1);
      `CHK(r[1], 1'b1)
    end
    // 9-bit receive: filter off, filter passing, filter blocking
    wr(A_OPT, 8'h03);
    for (int k = 0; k < 3; k++) begin
      rnd();
      mp = k > 0;
      n = k == 1 || (k == 0 && seed[8]);
      wr(A_CTRL1, {2'b10, mp, 5'h10});
      p1.send({n, d}, 11, 16);
      repeat (8) @(posedge clk_i);
      rd(A_CTRL1, r);
      `CHK(r, rx_ctrl(2'b10, mp, n))
      rd(A_BUF1, r);
      if (!mp || n) `CHK(r, d)
    end
    tdone("nine bit");
    // port 0 on its dedicated timer counting clocks, overflow every 3
    wr(A_RUN, 8'h21);
    wr(A_CLKSEL, 8'h01);
    wr(A_TRLD, 8'hFD);
    wr(A_TCNT, 8'hFD);
    rd(A_TRLD, r);
    `CHK(r, 8'hFD)
    wr(A_OPT, 8'h05);
    wr(A_CTRL0, 8'h50);
    rnd();
    p0.send({1'b1, d}, 10, 48);
    repeat (8) @(posedge clk_i);
    rd(A_CTRL0, r);
    `CHK(r, rx_ctrl(2'b01, 1'b0, 1'b1))
    rd(A_BUF0, r);
    `CHK(r, d)
    // bad stop bit with the filter on is dropped
    wr(A_CTRL0, 8'h70);
    p0.send({1'b0, d}, 10, 48);
    repeat (8) @(posedge clk_i);
    rd(A_CTRL0, r);
    `CHK(r, rx_ctrl(2'b01, 1'b1, 1'b0))
    rnd();
    fork
      p0.recv(10, 48, v);
      wr(A_BUF0, d);
    join
    `CHK(v, {1'b1, d})
    wr(A_RUN, 8'h01);
    rd(A_TRLD, r);
    `CHK(r, 8'h00)
    tdone("eight bit");
    // shift mode on port 2: data on the data pin, clock on transmit pin
    rnd();
    t0 = cyc;
    fork
      for (int i = 0; i < 8; i++) begin
        @(posedge txd_o[2]);
        v[i] = rxd_o[2];
      end
      wr(A_BUF2, d);
    join
    `CHK(v[7:0], d)
    poll(A_CTRL2, 1);
    `CHK(cyc - t0 > 100 && cyc - t0 < 125, 1'b1)
    wr(A_CTRL2, 8'h10);
    t0 = cyc;
    poll(A_CTRL2, 0);
    `CHK(cyc - t0 > 100 && cyc - t0 < 125, 1'b1)
    rd(A_BUF2, r);
    `CHK(r, 8'hFF)
    tdone("shift");
    wrap_up();
  end
endmodule
`default_nettype wire
